// >>> logic/bpcs_pkg.sv
// constants for the bridge primary command and status register block
package bpcs_pkg;
   // byte offsets of the configuration header dwords held here
   localparam logic [7:0] OFF_ID = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_STEP = 8'h08;
   // identity values, arbitrary
   localparam logic [15:0] PART_ID_VAL = 16'h5A3C;
   localparam logic [15:0] MAKER_ID_VAL = 16'h1D1D;
   localparam logic [7:0] STEP_VAL = 8'h01;
   // control bit positions
   localparam int C_IO = 0;
   localparam int C_MEM = 1;
   localparam int C_MST = 2;
   localparam int C_PER = 6;
   localparam int C_SERR = 8;
   localparam int C_IDIS = 10;
   // read-only control bit positions
   localparam int C_SPC = 3;
   localparam int C_MWI = 4;
   localparam int C_VGA = 5;
   localparam int C_WAIT = 7;
   localparam int C_FBB = 9;
   // writable control bits
   localparam logic [15:0] CTRL_WMASK = 16'h0547;
   // status half starts here in the dword; select timing field position
   localparam int STAT_LSB = 16;
   localparam int S_TIM = 9;
   // status flags that hardware sets and software clears
   localparam logic [15:0] STAT_W1C_MASK = 16'hF900;
   // status bit positions within the upper half
   localparam int S_CAP = 4;
   localparam int S_MDPE = 8;
   localparam int S_STA = 11;
   localparam int S_RTA = 12;
   localparam int S_RMA = 13;
   localparam int S_SSE = 14;
   localparam int S_DPE = 15;
   // fixed status bits: only capability list set
   localparam logic [15:0] STAT_FIXED = 16'h0010;
endpackage : bpcs_pkg

// >>> logic/bpcs_regs.sv
// primary command and status registers of the bridge configuration header
//
// What this block does
// [RQ1] control bit 0 clear makes primary I/O requests ignored
// [RQ2] control bit 1 clear makes primary memory requests ignored
// [RQ3] bit 2 clear: no primary mastering, no secondary memory/I/O claim
// [RQ4] bit 2 set: bridge masters forwarded requests on the primary
// [RQ5] control bit 3 is read-only zero; no special cycles
// [RQ6] control bit 4 reads zero; never originates write-and-invalidate
// [RQ7] control bits 5, 7 and 9 are read-only zero
// [RQ8] control bit 6 gates setting of master data parity error flag
// [RQ9] control bit 8 enables fatal and non-fatal error messages
// [RQ10] control bit 10 set holds legacy interrupt A deasserted
// [RQ11] status bit 20 reads one: capability list present
// [RQ12] status bits 21, 23, 19:16 and 22 read zero
// [RQ13] bit 24 sets on poisoned completion or poisoned write, if enabled
// [RQ14] status field 26:25 always reads 00
// [RQ15] bit 27 sets when bridge completes with completer abort
// [RQ16] bit 28 sets when completer abort completion received
// [RQ17] bit 29 sets when unsupported request completion received
// [RQ18] bit 30 sets when error message sent on primary
// [RQ19] bit 31 sets on any poisoned TLP detected on primary
// [RQ20] offset 00h bits 31:16 return fixed part identifier
// [RQ21] status flags clear only on written ones
// [RQ22] writes to read-only or reserved bits have no effect
// [RQ23] control bits and status flags reset to zero
`timescale 1ns/1ps
module bpcs_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // configuration access
   input wire logic cfg_rd_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // primary side events
   input wire logic ev_poison_cpl_i,
   input wire logic ev_poison_wr_i,
   input wire logic ev_poison_any_i,
   input wire logic ev_sig_abort_i,
   input wire logic ev_rcv_abort_i,
   input wire logic ev_rcv_unsup_i,
   input wire logic err_msg_req_i,
   // decode and master requests from the datapath
   input wire logic pri_io_req_i,
   input wire logic pri_mem_req_i,
   input wire logic sec_req_i,
   input wire logic irq_req_i,
   // enables and grants to the datapath
   output logic pri_io_claim_o,
   output logic pri_mem_claim_o,
   output logic pri_master_en_o,
   output logic sec_claim_o,
   output logic err_msg_send_o,
   output logic legacy_irq_a_n_o
);
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [15:0] stat_reg;
   logic [15:0] stat_next;
   logic [15:0] ev_vec;
   logic [15:0] clr_vec;
   logic [31:0] rd_next;
   logic wr_ctrl;
   logic sel_id;
   logic sel_ctrl;
   logic sel_step;
   logic [31:0] rd_id;
   logic [31:0] rd_ctrl;
   logic [31:0] rd_step;

   // write decode of the control and status dword
   assign wr_ctrl = cfg_wr_i && (cfg_addr_i == bpcs_pkg::OFF_CTRL);
   // only writable control bits move [RQ22] [RQ5] [RQ6] [RQ7]
   assign ctrl_next = wr_ctrl ?
      ((ctrl_reg & ~(bpcs_pkg::CTRL_WMASK & {{8{cfg_be_i[1]}},
         {8{cfg_be_i[0]}}})) |
       (cfg_wdata_i[15:0] & bpcs_pkg::CTRL_WMASK &
        {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}})) : ctrl_reg;

   // event vector into status flags
   always_comb
   begin
      ev_vec = 16'h0000;
      ev_vec[bpcs_pkg::S_MDPE] = ctrl_reg[bpcs_pkg::C_PER] &&
         (ev_poison_cpl_i || ev_poison_wr_i); // [RQ8] [RQ13]
      ev_vec[bpcs_pkg::S_STA] = ev_sig_abort_i; // [RQ15]
      ev_vec[bpcs_pkg::S_RTA] = ev_rcv_abort_i; // [RQ16]
      ev_vec[bpcs_pkg::S_RMA] = ev_rcv_unsup_i; // [RQ17]
      ev_vec[bpcs_pkg::S_SSE] = err_msg_req_i &&
         ctrl_reg[bpcs_pkg::C_SERR]; // [RQ18]
      ev_vec[bpcs_pkg::S_DPE] = ev_poison_any_i; // [RQ19]
   end

   // write one to clear, set wins over clear [RQ21]
   assign clr_vec = wr_ctrl ?
      (cfg_wdata_i[31:16] & {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}}) :
      16'h0000;
   assign stat_next = (stat_reg & ~clr_vec) | ev_vec;

   // read data select, fixed bits outside the flags [RQ11] [RQ12] [RQ14]
   assign sel_id = (cfg_addr_i == bpcs_pkg::OFF_ID);
   assign sel_ctrl = (cfg_addr_i == bpcs_pkg::OFF_CTRL);
   assign sel_step = (cfg_addr_i == bpcs_pkg::OFF_STEP);
   assign rd_id = {bpcs_pkg::PART_ID_VAL, bpcs_pkg::MAKER_ID_VAL}; // [RQ20]
   assign rd_ctrl = {stat_reg | bpcs_pkg::STAT_FIXED, ctrl_reg};
   assign rd_step = {24'h00_0000, bpcs_pkg::STEP_VAL};
   assign rd_next = sel_id ? rd_id :
      sel_ctrl ? rd_ctrl : sel_step ? rd_step : 32'h0000_0000;

   // register state [RQ23]
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_reg <= 16'h0000;
         stat_reg <= 16'h0000;
         cfg_rdata_o <= 32'h0000_0000;
         cfg_rvalid_o <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         stat_reg <= stat_next;
         cfg_rdata_o <= cfg_rd_i ? rd_next : 32'h0000_0000;
         cfg_rvalid_o <= cfg_rd_i;
      end
   end

   // gated enables to the datapath
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pri_io_claim_o <= 1'b0;
         pri_mem_claim_o <= 1'b0;
         pri_master_en_o <= 1'b0;
         sec_claim_o <= 1'b0;
         err_msg_send_o <= 1'b0;
         legacy_irq_a_n_o <= 1'b1;
      end
      else
      begin
         pri_io_claim_o <= pri_io_req_i && ctrl_reg[bpcs_pkg::C_IO]; // [RQ1]
         pri_mem_claim_o <= pri_mem_req_i &&
            ctrl_reg[bpcs_pkg::C_MEM]; // [RQ2]
         pri_master_en_o <= ctrl_reg[bpcs_pkg::C_MST]; // [RQ3] [RQ4]
         sec_claim_o <= sec_req_i && ctrl_reg[bpcs_pkg::C_MST]; // [RQ3]
         err_msg_send_o <= err_msg_req_i &&
            ctrl_reg[bpcs_pkg::C_SERR]; // [RQ9]
         legacy_irq_a_n_o <= !(irq_req_i &&
            !ctrl_reg[bpcs_pkg::C_IDIS]); // [RQ10]
      end
   end

   // named steps used by the checks below
   sequence s_ctrl_read;
      cfg_rd_i && cfg_addr_i == bpcs_pkg::OFF_CTRL;
   endsequence
   sequence s_id_read;
      cfg_rd_i && cfg_addr_i == bpcs_pkg::OFF_ID;
   endsequence
   sequence s_parity_event;
      ctrl_reg[bpcs_pkg::C_PER] && (ev_poison_cpl_i || ev_poison_wr_i);
   endsequence
   sequence s_msg_event;
      err_msg_req_i && ctrl_reg[bpcs_pkg::C_SERR];
   endsequence
   sequence s_abort_clear;
      clr_vec[bpcs_pkg::S_RTA] && !ev_rcv_abort_i;
   endsequence
   // io claim only behind an enabled io space
   a_io_gate: assert property (@(posedge clk_i) // [RQ1]
      disable iff (!nrst_i)
      pri_io_claim_o |-> $past(ctrl_reg[bpcs_pkg::C_IO]))
      else $error("io claimed while disabled");
   // enabled io space passes the request on
   a_io_follow: assert property (@(posedge clk_i) // [RQ1]
      disable iff (!nrst_i)
      pri_io_req_i && ctrl_reg[bpcs_pkg::C_IO] |=> pri_io_claim_o)
      else $error("io request not claimed");
   // memory claim only behind an enabled memory space
   a_mem_gate: assert property (@(posedge clk_i) // [RQ2]
      disable iff (!nrst_i)
      pri_mem_claim_o |-> $past(ctrl_reg[bpcs_pkg::C_MEM]))
      else $error("memory claimed while disabled");
   // enabled memory space passes the request on
   a_mem_follow: assert property (@(posedge clk_i) // [RQ2]
      disable iff (!nrst_i)
      pri_mem_req_i && ctrl_reg[bpcs_pkg::C_MEM] |=> pri_mem_claim_o)
      else $error("memory request not claimed");
   // secondary claim needs master enable
   a_sec_gate: assert property (@(posedge clk_i) // [RQ3]
      disable iff (!nrst_i)
      sec_claim_o |-> $past(ctrl_reg[bpcs_pkg::C_MST]) && pri_master_en_o)
      else $error("secondary claim without master enable");
   // master enable off silences both sides
   a_mst_off: assert property (@(posedge clk_i) // [RQ3]
      disable iff (!nrst_i)
      !ctrl_reg[bpcs_pkg::C_MST] |=> !pri_master_en_o && !sec_claim_o)
      else $error("mastering while disabled");
   // master enable on reaches the datapath
   a_mst_on: assert property (@(posedge clk_i) // [RQ4]
      disable iff (!nrst_i)
      ctrl_reg[bpcs_pkg::C_MST] |=> pri_master_en_o)
      else $error("master enable not passed on");
   // special cycle bit reads zero
   a_spc_zero: assert property (@(posedge clk_i) // [RQ5]
      disable iff (!nrst_i)
      s_ctrl_read |=> !cfg_rdata_o[bpcs_pkg::C_SPC])
      else $error("special cycle bit set");
   // write-and-invalidate bit reads zero
   a_mwi_zero: assert property (@(posedge clk_i) // [RQ6]
      disable iff (!nrst_i)
      s_ctrl_read |=> !cfg_rdata_o[bpcs_pkg::C_MWI])
      else $error("write-and-invalidate bit set");
   // unsupported control bits read zero
   a_unsup_zero: assert property (@(posedge clk_i) // [RQ7]
      disable iff (!nrst_i)
      s_ctrl_read |=> !cfg_rdata_o[bpcs_pkg::C_VGA] &&
      !cfg_rdata_o[bpcs_pkg::C_WAIT] && !cfg_rdata_o[bpcs_pkg::C_FBB])
      else $error("unsupported control bit set");
   // parity response off keeps the parity flag low
   a_mdpe_quiet: assert property (@(posedge clk_i) // [RQ8]
      disable iff (!nrst_i)
      !ctrl_reg[bpcs_pkg::C_PER] && !stat_reg[bpcs_pkg::S_MDPE]
      |=> !stat_reg[bpcs_pkg::S_MDPE])
      else $error("parity flag set while response off");
   // error message only with message enable
   a_msg_gate: assert property (@(posedge clk_i) // [RQ9]
      disable iff (!nrst_i)
      err_msg_send_o |-> $past(ctrl_reg[bpcs_pkg::C_SERR]))
      else $error("error message while disabled");
   // enabled error message is sent
   a_msg_follow: assert property (@(posedge clk_i) // [RQ9]
      disable iff (!nrst_i)
      s_msg_event |=> err_msg_send_o)
      else $error("error message not sent");
   // interrupt disable holds the line high
   a_irq_block: assert property (@(posedge clk_i) // [RQ10]
      disable iff (!nrst_i)
      $past(ctrl_reg[bpcs_pkg::C_IDIS]) |-> legacy_irq_a_n_o)
      else $error("interrupt asserted while disabled");
   // interrupt allowed reaches the line
   a_irq_pass: assert property (@(posedge clk_i) // [RQ10]
      disable iff (!nrst_i)
      irq_req_i && !ctrl_reg[bpcs_pkg::C_IDIS] |=> !legacy_irq_a_n_o)
      else $error("interrupt not asserted");
   // capability list bit reads one
   a_cap_read: assert property (@(posedge clk_i) // [RQ11]
      disable iff (!nrst_i)
      s_ctrl_read |=> cfg_rdata_o[bpcs_pkg::STAT_LSB + bpcs_pkg::S_CAP])
      else $error("capability bit clear");
   // fixed and reserved status bits read zero
   a_stat_zero: assert property (@(posedge clk_i) // [RQ12]
      disable iff (!nrst_i)
      s_ctrl_read |=> (cfg_rdata_o[bpcs_pkg::STAT_LSB +: 16] &
      ~(bpcs_pkg::STAT_W1C_MASK | bpcs_pkg::STAT_FIXED)) == 16'h0000)
      else $error("reserved status bit set");
   // parity event with response on sets the flag
   a_mdpe_set: assert property (@(posedge clk_i) // [RQ13]
      disable iff (!nrst_i)
      s_parity_event |=> stat_reg[bpcs_pkg::S_MDPE])
      else $error("parity flag not set");
   // parity flag rises only with response on
   a_mdpe_gate: assert property (@(posedge clk_i) // [RQ13]
      disable iff (!nrst_i)
      $rose(stat_reg[bpcs_pkg::S_MDPE]) |-> $past(ctrl_reg[bpcs_pkg::C_PER]))
      else $error("parity flag set while response off");
   // select timing field reads zero
   a_timing_zero: assert property (@(posedge clk_i) // [RQ14]
      disable iff (!nrst_i)
      s_ctrl_read |=>
      cfg_rdata_o[bpcs_pkg::STAT_LSB + bpcs_pkg::S_TIM +: 2] == 2'h0)
      else $error("select timing field set");
   // signalled abort flag
   a_sta_set: assert property (@(posedge clk_i) // [RQ15]
      disable iff (!nrst_i)
      ev_sig_abort_i |=> stat_reg[bpcs_pkg::S_STA])
      else $error("signalled abort flag not set");
   // received abort flag
   a_rta_set: assert property (@(posedge clk_i) // [RQ16]
      disable iff (!nrst_i)
      ev_rcv_abort_i |=> stat_reg[bpcs_pkg::S_RTA])
      else $error("received abort flag not set");
   // unsupported request flag
   a_rma_set: assert property (@(posedge clk_i) // [RQ17]
      disable iff (!nrst_i)
      ev_rcv_unsup_i |=> stat_reg[bpcs_pkg::S_RMA])
      else $error("unsupported flag not set");
   // sent error message sets its flag
   a_sse_set: assert property (@(posedge clk_i) // [RQ18]
      disable iff (!nrst_i)
      s_msg_event |=> stat_reg[bpcs_pkg::S_SSE])
      else $error("error message flag not set");
   // error message flag rises only with a sent message
   a_sse_gate: assert property (@(posedge clk_i) // [RQ18]
      disable iff (!nrst_i)
      $rose(stat_reg[bpcs_pkg::S_SSE]) |-> err_msg_send_o)
      else $error("error message flag without message");
   // any poisoned packet sets the detected flag
   a_dpe_set: assert property (@(posedge clk_i) // [RQ19]
      disable iff (!nrst_i)
      ev_poison_any_i |=> stat_reg[bpcs_pkg::S_DPE])
      else $error("poison flag not set");
   // identifier read returns the fixed code
   a_id_read: assert property (@(posedge clk_i) // [RQ20]
      disable iff (!nrst_i)
      s_id_read |=>
      cfg_rdata_o[bpcs_pkg::STAT_LSB +: 16] == bpcs_pkg::PART_ID_VAL)
      else $error("identifier wrong");
   // flag kept without a written one
   a_clear_one: assert property (@(posedge clk_i) // [RQ21]
      disable iff (!nrst_i)
      stat_reg[bpcs_pkg::S_RTA] && !clr_vec[bpcs_pkg::S_RTA]
      |=> stat_reg[bpcs_pkg::S_RTA])
      else $error("flag lost without written one");
   // written one clears the flag
   a_clear_done: assert property (@(posedge clk_i) // [RQ21]
      disable iff (!nrst_i)
      s_abort_clear |=> !stat_reg[bpcs_pkg::S_RTA])
      else $error("flag not cleared by written one");
   // event in the clearing cycle wins
   a_set_wins: assert property (@(posedge clk_i) // [RQ21]
      disable iff (!nrst_i)
      clr_vec[bpcs_pkg::S_DPE] && ev_poison_any_i |=> stat_reg[bpcs_pkg::S_DPE])
      else $error("clear beat a new event");
   // read-only control bits never set
   a_ro_ctrl: assert property (@(posedge clk_i) // [RQ22]
      disable iff (!nrst_i)
      (ctrl_reg & ~bpcs_pkg::CTRL_WMASK) == 16'h0000)
      else $error("read-only control bit set");
   // control only moves on a control write
   a_ctrl_hold: assert property (@(posedge clk_i) // [RQ22]
      disable iff (!nrst_i)
      !wr_ctrl |=> $stable(ctrl_reg))
      else $error("control changed without write");
   // registers leave reset cleared
   a_reset_clear: assert property (@(posedge clk_i) // [RQ23]
      disable iff (!nrst_i)
      $rose(nrst_i) |-> ctrl_reg == 16'h0000 && stat_reg == 16'h0000)
      else $error("register not cleared by reset");
   // outputs leave reset idle
   a_reset_outs: assert property (@(posedge clk_i) // [RQ23]
      disable iff (!nrst_i)
      $rose(nrst_i) |-> legacy_irq_a_n_o && !pri_master_en_o && !cfg_rvalid_o)
      else $error("output not idle after reset");
endmodule : bpcs_regs

// >>> tb/bpcs_rc_model.sv
// configuration requester standing in for the root complex
`timescale 1ns/1ps
module bpcs_rc_model (
   // clock
   input wire logic clk_i,
   // configuration requests
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] addr_o,
   output logic [3:0] be_o,
   output logic [31:0] wdata_o
);
   initial {rd_o, wr_o, addr_o, be_o, wdata_o} = '0;
   // one-cycle request; released address and data are scrambled, byte enables left stale
   task automatic issue(input logic r, input logic w, input logic [7:0] a,
      input logic [3:0] b, input logic [31:0] d);
      @(posedge clk_i);
      rd_o <= r;
      wr_o <= w;
      addr_o <= a;
      be_o <= b;
      wdata_o <= d;
      @(posedge clk_i);
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : issue
endmodule : bpcs_rc_model

// >>> tb/tb.sv
// self-checking bench for the primary command and status registers
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [6:0] evs = '0;
   logic [3:0] reqs = '0;
   logic rd, wr, rvalid;
   logic [7:0] addr;
   logic [3:0] be;
   logic [31:0] wdata, rdata, d, r;
   logic [5:0] outs, e6;
   logic [31:0] q[$];
   int err_count = 0;
   int total_checks = 0;
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   bpcs_rc_model rc (.clk_i(clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr),
      .be_o(be), .wdata_o(wdata));
   bpcs_regs DUT (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_rd_i(rd),
      .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
      .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
      .ev_poison_cpl_i(evs[0]), .ev_poison_wr_i(evs[1]),
      .ev_poison_any_i(evs[2]), .ev_sig_abort_i(evs[3]),
      .ev_rcv_abort_i(evs[4]), .ev_rcv_unsup_i(evs[5]),
      .err_msg_req_i(evs[6]), .pri_io_req_i(reqs[0]),
      .pri_mem_req_i(reqs[1]), .sec_req_i(reqs[2]), .irq_req_i(reqs[3]),
      .pri_io_claim_o(outs[5]), .pri_mem_claim_o(outs[4]),
      .pri_master_en_o(outs[3]), .sec_claim_o(outs[2]),
      .err_msg_send_o(outs[1]), .legacy_irq_a_n_o(outs[0]));
   // single compare for every read result
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic chk_gates(input logic [5:0] e, input logic [5:0] s);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH gates expected %h seen %h", e, s);
      end
   endtask : chk_gates
   task automatic rd32(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      rc.issue(1'b1, 1'b0, a, 4'hF, 32'h0);
   endtask : rd32
   task automatic wr32(input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] v);
      rc.issue(1'b0, 1'b1, a, b, v);
   endtask : wr32
   task automatic pulse(input logic [6:0] v);
      @(posedge clk_i);
      evs <= v;
      @(posedge clk_i);
      evs <= '0;
   endtask : pulse
   // drain pending reads under a bound, then report
   task automatic print_verdict;
      for (int n = 0; n < 20 && q.size() != 0; n++) @(posedge clk_i);
      if (q.size() != 0) err_count++;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // read answers matched against oldest note
   always @(posedge clk_i)
      if (rvalid === 1'b1)
      begin
         if (q.size() == 0)
         begin
            err_count++;
            $display("MISMATCH rdata expected none seen %h", rdata);
         end
         else chk("rdata", q.pop_front(), rdata);
      end
   initial
   begin
      void'($urandom(49123));
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      wr32(8'h00, 4'hF, 32'hFFFFFFFF);
      rd32(8'h00, {bpcs_pkg::PART_ID_VAL, bpcs_pkg::MAKER_ID_VAL});
      rd32(8'h08, {24'h000000, bpcs_pkg::STEP_VAL});
      rd32(8'h0C, 32'h00000000);
      rd32(8'h04, 32'h00100000);
      wr32(8'h04, 4'h3, 32'hFFFFFFFF);
      rd32(8'h04, 32'h00100547);
      $display("test ident done");
      pulse(7'h7F);
      rd32(8'h04, 32'hF9100547);
      wr32(8'h04, 4'hC, 32'h00000000);
      wr32(8'h04, 4'hC, 32'h09000000);
      rd32(8'h04, 32'hF0100547);
      wr32(8'h04, 4'h8, 32'hFFFFFFFF);
      wr32(8'h04, 4'h3, 32'hFFFF0000);
      pulse(7'h43);
      rd32(8'h04, 32'h00100000);
      pulse(7'h04);
      rd32(8'h04, 32'h80100000);
      $display("test status done");
      repeat (16)
      begin
         d = $urandom;
         r = $urandom;
         @(posedge clk_i);
         reqs <= r[3:0];
         evs <= {r[4], 6'h00};
         wr32(8'h04, 4'h3, d);
         repeat (2) @(posedge clk_i);
         #1;
         e6 = {r[0] & d[0], r[1] & d[1], d[2], r[2] & d[2], r[4] & d[8],
            ~(r[3] & ~d[10])};
         chk_gates(e6, outs);
      end
      $display("test gates done");
      @(posedge clk_i);
      evs <= '0;
      nrst_i <= 1'b0;
      @(posedge clk_i);
      nrst_i <= 1'b1;
      rd32(8'h04, 32'h00100000);
      $display("test reset done");
      print_verdict();
   end
endmodule : tb
